// file: logic/gfc_bank.sv
`timescale 1ns/100ps
module gfc_bank #(
	parameter logic [7:0] DEVICE_IDENTIFICATION = 8'h5a,
	parameter logic [7:0] DEVICE_REV = 8'h01,
	parameter logic [7:0] FLOPPY_LDN = 8'h00,
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// host i/o pins
	input wire gfc_pkg::gfc_bus_t host_bus,
	output logic [7:0] host_rdata,
	output logic host_rdata_oe,
	// reset sources and strap
	input wire logic host_hard_reset_input,
	input wire logic main_por,
	input wire logic standby_por,
	input wire logic strap_sel,
	// configuration outputs
	output logic config_mode,
	output gfc_pkg::gfc_global_cfg_t global_cfg,
	output gfc_pkg::gfc_floppy_cfg_t floppy_function
);
	import gfc_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (SYNC_STAGES < 2)
		begin : g_bad_sync
			$error("sync depth below two stages");
		end
		if (GFC_E_DB != GFC_NREG - 1)
		begin : g_bad_table
			$error("register table size mismatch");
		end
	endgenerate

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	gfc_in_t pin_raw;
	gfc_in_t sync_q [SYNC_STAGES];
	gfc_in_t pins;

	always_comb
	begin
		pin_raw.bus = host_bus;
		pin_raw.hard = host_hard_reset_input;
		pin_raw.main_por = main_por;
		pin_raw.stby_por = standby_por;
		pin_raw.strap = strap_sel;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int s = 0; s < SYNC_STAGES; s++)
			begin
				sync_q[s] <= GFC_IN_IDLE;
			end
		end
		else
		begin
			sync_q[0] <= pin_raw;
			for (int s = 1; s < SYNC_STAGES; s++)
			begin
				sync_q[s] <= sync_q[s-1];
			end
		end
	end

	assign pins = sync_q[SYNC_STAGES-1];

	// ----------------------------------------
	// write strobe edge
	// ----------------------------------------
	logic wr_prev_q;
	logic wr_ev;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_prev_q <= 1'b1;
		end
		else
		begin
			wr_prev_q <= pins.bus.wr_n;
		end
	end

	assign wr_ev = wr_prev_q & ~pins.bus.wr_n;

	// ----------------------------------------
	// reset classes
	// ----------------------------------------
	logic soft_q;
	logic [GFC_NCLS-1:0] clr;

	always_comb
	begin
		clr = '0;
		clr[GFC_C_HMS] = pins.hard | pins.main_por | pins.stby_por;
		clr[GFC_C_ALL] = pins.hard | pins.main_por | pins.stby_por | soft_q;
		clr[GFC_C_HM] = pins.hard | pins.main_por;
		clr[GFC_C_HMSOFT] = pins.hard | pins.main_por | soft_q;
		clr[GFC_C_MS] = pins.main_por | pins.stby_por;
	end

	// ----------------------------------------
	// strap capture after release
	// ----------------------------------------
	logic [1:0] init_q;
	logic init_load;
	logic [7:0] strap_rst;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			init_q <= 2'h0;
		end
		else if (init_q != 2'h3)
		begin
			init_q <= init_q + 2'h1;
		end
	end

	assign init_load = (init_q == GFC_STRAP_WAIT);
	assign strap_rst = pins.strap ? GFC_CPL_STRAP_HI : GFC_CPL_STRAP_LO;

	// ----------------------------------------
	// port decode
	// ----------------------------------------
	logic [7:0] reg_q [GFC_NREG];
	logic [15:0] port_addr;
	logic at_index;
	logic at_data;
	gfc_state_t state_q;
	logic data_wr;

	assign port_addr = {reg_q[GFC_E_CPH], reg_q[GFC_E_CPL]};
	assign at_index = (pins.bus.addr == port_addr);
	assign at_data = (pins.bus.addr == port_addr + GFC_DATA_OFS);
	assign data_wr = (state_q == GFC_CFG) & wr_ev & at_data;

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= GFC_RUN;
		end
		else if (clr[GFC_C_HMS])
		begin
			state_q <= GFC_RUN;
		end
		else
		begin
			case (state_q)
				GFC_RUN:
				begin
					if (wr_ev && at_index && pins.bus.data == GFC_KEY_ENTER)
					begin
						state_q <= GFC_CFG;
					end
				end
				GFC_CFG:
				begin
					if (wr_ev && at_index && pins.bus.data == GFC_KEY_EXIT)
					begin
						state_q <= GFC_RUN;
					end
				end
				default:
				begin
					state_q <= GFC_RUN;
				end
			endcase
		end
	end

	assign config_mode = (state_q == GFC_CFG);

	// ----------------------------------------
	// index pointer
	// ----------------------------------------
	logic [7:0] index_q;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			index_q <= 8'h00;
		end
		else if (clr[GFC_C_HMS])
		begin
			index_q <= 8'h00;
		end
		else if (state_q == GFC_CFG && wr_ev && at_index && pins.bus.data != GFC_KEY_EXIT)
		begin
			index_q <= pins.bus.data;
		end
	end

	// ----------------------------------------
	// soft reset pulse
	// ----------------------------------------
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			soft_q <= 1'b0;
		end
		else
		begin
			soft_q <= data_wr & (index_q == GFC_IDX[GFC_E_CTRL]) &
				pins.bus.data[GFC_SOFT_BIT];
		end
	end

	// ----------------------------------------
	// register array
	// ----------------------------------------
	logic [GFC_NREG-1:0] reach;
	logic [GFC_NREG-1:0] wr_hit;

	generate
		for (genvar i = 0; i < GFC_NREG; i++)
		begin : g_reg
			assign reach[i] = (GFC_IDX[i] < GFC_GLOBAL_TOP) ||
				(reg_q[GFC_E_LDN] == FLOPPY_LDN);
			assign wr_hit[i] = data_wr & (index_q == GFC_IDX[i]) & reach[i];

			if (i == GFC_E_CPL)
			begin : g_strap
				always_ff @(posedge clock or negedge arst_n)
				begin
					if (!arst_n)
					begin
						reg_q[i] <= GFC_RST[i];
					end
					else if (clr[GFC_CLS[i]] || init_load)
					begin
						reg_q[i] <= strap_rst;
					end
					else if (wr_hit[i])
					begin
						reg_q[i] <= pins.bus.data;
					end
				end
			end
			else
			begin : g_plain
				always_ff @(posedge clock or negedge arst_n)
				begin
					if (!arst_n)
					begin
						reg_q[i] <= GFC_RST[i];
					end
					else if (clr[GFC_CLS[i]])
					begin
						reg_q[i] <= GFC_RST[i];
					end
					else if (wr_hit[i])
					begin
						reg_q[i] <= pins.bus.data;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [7:0] rd_val;
	logic rd_act;

	assign rd_act = ~pins.bus.rd_n & (state_q == GFC_CFG) & (at_index | at_data);

	always_comb
	begin
		rd_val = 8'h00;
		if (at_index)
		begin
			rd_val = index_q;
		end
		else if (index_q == GFC_IDX_ID)
		begin
			rd_val = DEVICE_IDENTIFICATION;
		end
		else if (index_q == GFC_IDX_REV)
		begin
			rd_val = DEVICE_REV;
		end
		else
		begin
			for (int k = 0; k < GFC_NREG; k++)
			begin
				if (k != GFC_E_CTRL && index_q == GFC_IDX[k] && reach[k])
				begin
					rd_val = reg_q[k];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_rdata <= 8'h00;
			host_rdata_oe <= 1'b0;
		end
		else
		begin
			host_rdata <= rd_act ? rd_val : 8'h00;
			host_rdata_oe <= rd_act;
		end
	end

	// ----------------------------------------
	// configuration outputs
	// ----------------------------------------
	always_comb
	begin
		global_cfg.ldn = reg_q[GFC_E_LDN];
		global_cfg.power_ctrl = reg_q[GFC_E_PWRC];
		global_cfg.power_mgmt = reg_q[GFC_E_PM];
		global_cfg.osc = reg_q[GFC_E_OSC];
		global_cfg.clock_mask = reg_q[GFC_E_CLKM];
		global_cfg.port_addr = port_addr;
		floppy_function.activate = reg_q[GFC_E_ACT];
		floppy_function.base = {reg_q[GFC_E_BH], reg_q[GFC_E_BL]};
		floppy_function.irq = reg_q[GFC_E_IRQ];
		floppy_function.dma = reg_q[GFC_E_DMA];
		floppy_function.mode = reg_q[GFC_E_MODE];
		floppy_function.option = reg_q[GFC_E_OPT];
		floppy_function.drive_type = reg_q[GFC_E_TYPE];
		floppy_function.drive_a = reg_q[GFC_E_DA];
		floppy_function.drive_b = reg_q[GFC_E_DB];
	end

endmodule

// file: logic/gfc_pkg.sv
package gfc_pkg;

	// ----------------------------------------
	// key values and fixed indices
	// ----------------------------------------
	localparam logic [7:0] GFC_KEY_ENTER = 8'h55;
	localparam logic [7:0] GFC_KEY_EXIT = 8'haa;
	localparam logic [7:0] GFC_IDX_ID = 8'h20;
	localparam logic [7:0] GFC_IDX_REV = 8'h21;
	localparam logic [7:0] GFC_GLOBAL_TOP = 8'h30;
	localparam logic [7:0] GFC_CPL_STRAP_LO = 8'hf0;
	localparam logic [7:0] GFC_CPL_STRAP_HI = 8'h70;
	localparam logic [15:0] GFC_DATA_OFS = 16'h0001;
	localparam int GFC_SOFT_BIT = 0;
	localparam logic [1:0] GFC_STRAP_WAIT = 2'h2;

	// ----------------------------------------
	// reset classes
	// ----------------------------------------
	localparam int GFC_C_HMS = 0;
	localparam int GFC_C_ALL = 1;
	localparam int GFC_C_HM = 2;
	localparam int GFC_C_HMSOFT = 3;
	localparam int GFC_C_MS = 4;
	localparam int GFC_NCLS = 5;

	// ----------------------------------------
	// register entries
	// ----------------------------------------
	localparam int GFC_NREG = 24;
	localparam int GFC_E_CTRL = 0;
	localparam int GFC_E_IDX = 1;
	localparam int GFC_E_LDN = 2;
	localparam int GFC_E_PWRC = 3;
	localparam int GFC_E_PM = 4;
	localparam int GFC_E_OSC = 5;
	localparam int GFC_E_CPL = 6;
	localparam int GFC_E_CPH = 7;
	localparam int GFC_E_CLKM = 8;
	localparam int GFC_E_ACT = 14;
	localparam int GFC_E_BH = 15;
	localparam int GFC_E_BL = 16;
	localparam int GFC_E_IRQ = 17;
	localparam int GFC_E_DMA = 18;
	localparam int GFC_E_MODE = 19;
	localparam int GFC_E_OPT = 20;
	localparam int GFC_E_TYPE = 21;
	localparam int GFC_E_DA = 22;
	localparam int GFC_E_DB = 23;

	localparam logic [7:0] GFC_IDX [GFC_NREG] = '{8'h02, 8'h03, 8'h07, 8'h22, 8'h23, 8'h24,
		8'h26, 8'h27, 8'h28, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h60, 8'h61, 8'h70,
		8'h74, 8'hf0, 8'hf1, 8'hf2, 8'hf4, 8'hf5};
	localparam logic [7:0] GFC_RST [GFC_NREG] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04,
		8'hf0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hf0, 8'h06,
		8'h02, 8'h0e, 8'h00, 8'hff, 8'h00, 8'h00};
	localparam int GFC_CLS [GFC_NREG] = '{GFC_C_HMS, GFC_C_HMS, GFC_C_ALL, GFC_C_ALL,
		GFC_C_HMS, GFC_C_HMS, GFC_C_HM, GFC_C_HM, GFC_C_HMSOFT, GFC_C_MS, GFC_C_MS, GFC_C_MS,
		GFC_C_MS, GFC_C_MS, GFC_C_ALL, GFC_C_ALL, GFC_C_ALL, GFC_C_ALL, GFC_C_ALL, GFC_C_HMS,
		GFC_C_HMS, GFC_C_HMS, GFC_C_HMS, GFC_C_HMS};

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {GFC_RUN = 2'b01, GFC_CFG = 2'b10} gfc_state_t;

	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic [15:0] addr;
		logic [7:0] data;
	} gfc_bus_t;

	typedef struct packed {
		gfc_bus_t bus;
		logic hard;
		logic main_por;
		logic stby_por;
		logic strap;
	} gfc_in_t;

	localparam gfc_in_t GFC_IN_IDLE = '{bus: '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000,
		data: 8'h00}, hard: 1'b0, main_por: 1'b0, stby_por: 1'b0, strap: 1'b0};

	typedef struct packed {
		logic [7:0] ldn;
		logic [7:0] power_ctrl;
		logic [7:0] power_mgmt;
		logic [7:0] osc;
		logic [7:0] clock_mask;
		logic [15:0] port_addr;
	} gfc_global_cfg_t;

	typedef struct packed {
		logic [7:0] activate;
		logic [15:0] base;
		logic [7:0] irq;
		logic [7:0] dma;
		logic [7:0] mode;
		logic [7:0] option;
		logic [7:0] drive_type;
		logic [7:0] drive_a;
		logic [7:0] drive_b;
	} gfc_floppy_cfg_t;

endpackage

// file: verif/gfc_bank_chk.sv
`timescale 1ns/100ps
module gfc_bank_chk (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// host pins
	input wire gfc_pkg::gfc_bus_t host_bus,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_oe,
	// reset sources and strap
	input wire logic host_hard_reset_input,
	input wire logic main_por,
	input wire logic standby_por,
	input wire logic strap_sel,
	// configuration
	input wire logic config_mode,
	input wire gfc_pkg::gfc_global_cfg_t global_cfg,
	input wire gfc_pkg::gfc_floppy_cfg_t floppy_function
);
	import gfc_pkg::*;
	wire logic any_rst = host_hard_reset_input || main_por || standby_por;
	wire logic only_stby = standby_por && !host_hard_reset_input && !main_por;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ----
	// reset values and no read data driven in run state
	// ----
	a_ldn_hard: assert property (host_hard_reset_input [*4] |-> global_cfg.ldn == 8'h00)
		else $error("device select not cleared by hard reset");
	a_port_main: assert property (main_por [*4] |->
		global_cfg.port_addr == (strap_sel ? 16'h0370 : 16'h03f0))
		else $error("port address wrong after main power-on");
	a_port_stby: assert property (only_stby |=> $stable(global_cfg.port_addr))
		else $error("port address changed by standby power-on");
	a_floppy_stby: assert property (standby_por [*4] |->
		floppy_function.irq == 8'h06 && floppy_function.dma == 8'h02)
		else $error("floppy irq or dma wrong after standby power-on");
	a_mode_main: assert property (main_por [*4] |->
		floppy_function.mode == 8'h0e && floppy_function.drive_type == 8'hff)
		else $error("floppy mode or type wrong after main power-on");
	a_clkm_hard: assert property (host_hard_reset_input [*4] |->
		global_cfg.clock_mask == 8'h00 && global_cfg.osc == 8'h04 &&
		global_cfg.power_mgmt == 8'h00)
		else $error("global registers wrong after hard reset");
	a_clkm_stby: assert property (only_stby |=> $stable(global_cfg.clock_mask))
		else $error("clock mask changed by standby power-on");
	a_run_quiet: assert property (!config_mode [*4] |-> !host_rdata_oe)
		else $error("data driven in run state");
	a_base_any: assert property (any_rst [*4] |->
		floppy_function.base == 16'h03f0 && floppy_function.activate == 8'h00)
		else $error("floppy base or activate wrong after reset");
	c_cfg: cover property ($rose(config_mode));
	c_read: cover property ($rose(host_rdata_oe));
	c_stby: cover property (standby_por [*4]);
endmodule

bind gfc_bank gfc_bank_chk i_gfc_bank_chk (.clock, .arst_n, .host_bus, .host_rdata,
	.host_rdata_oe, .host_hard_reset_input, .main_por, .standby_por, .strap_sel,
	.config_mode, .global_cfg, .floppy_function);

// file: verif/gfc_host.sv
`timescale 1ns/100ps
module gfc_host (
	// clock
	input wire logic clock,
	// device pins
	output gfc_pkg::gfc_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic rdata_oe
);
	import gfc_pkg::*;
	initial bus = GFC_IN_IDLE.bus;
	task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d,
		output logic [8:0] q);
		@(posedge clock);
		#1 bus.addr = a;
		bus.data = d;
		@(posedge clock);
		#1 bus.rd_n = !rd;
		bus.wr_n = rd;
		repeat (4) @(posedge clock);
		#1 q = {rdata_oe, rdata};
		bus.rd_n = 1'b1;
		bus.wr_n = 1'b1;
		repeat (3) @(posedge clock);
		#1 bus.addr = ~a;
		bus.data = ~d;
	endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
	import gfc_pkg::*;
	// arbitrary codes
	localparam logic [7:0] ID = 8'h3c;
	localparam logic [7:0] REV = 8'h09;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] rp = 3'h0;
	logic strap = 1'b0;
	gfc_bus_t bus;
	logic [7:0] rdata;
	logic oe;
	logic cfg;
	gfc_global_cfg_t gcfg;
	gfc_floppy_cfg_t fcfg;
	logic [7:0] m [int];
	logic [8:0] q;
	int error_cnt = 0;
	int comparisons = 0;
	int seed = 5;
	int p;
	gfc_bank #(.DEVICE_IDENTIFICATION(ID), .DEVICE_REV(REV)) i_gfc_bank (.clock(clock), .arst_n(arst_n),
		.host_bus(bus), .host_rdata(rdata), .host_rdata_oe(oe),
		.host_hard_reset_input(rp[0]), .main_por(rp[1]), .standby_por(rp[2]),
		.strap_sel(strap), .config_mode(cfg), .global_cfg(gcfg), .floppy_function(fcfg));
	gfc_host i_gfc_host (.clock(clock), .bus(bus), .rdata(rdata), .rdata_oe(oe));
	initial
	begin
		forever #5 clock = ~clock;
	end
	// ----
	// model: 0 hard, 1 main, 2 standby, 3 soft
	// ----
	task automatic mrst(input int s);
		if (s < 3)
		begin
			m[2] = 8'h00;
			m[3] = 8'h03;
			m[8'h23] = 8'h00;
			m[8'h24] = 8'h04;
			m[8'hf0] = 8'h0e;
			m[8'hf1] = 8'h00;
			m[8'hf2] = 8'hff;
			m[8'hf4] = 8'h00;
			m[8'hf5] = 8'h00;
		end
		m[7] = 8'h00;
		m[8'h22] = 8'h00;
		m[8'h30] = 8'h00;
		m[8'h60] = 8'h03;
		m[8'h61] = 8'hf0;
		m[8'h70] = 8'h06;
		m[8'h74] = 8'h02;
		if (s < 2)
		begin
			m[8'h26] = strap ? 8'h70 : 8'hf0;
			m[8'h27] = 8'h03;
		end
		if (s != 2)
			m[8'h28] = 8'h00;
		if (s == 1 || s == 2)
			for (int k = 8'h2b; k <= 8'h2f; k++)
				m[k] = 8'h00;
	endtask
	function automatic logic [15:0] port();
		return {m[8'h27], m[8'h26]};
	endfunction
	task automatic chk(input logic [79:0] e, input logic [79:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic outs();
		logic [79:0] eg;
		logic [79:0] ef;
		eg = {24'h000000, m[7], m[8'h22], m[8'h23], m[8'h24], m[8'h28], port()};
		ef = {m[8'h30], m[8'h60], m[8'h61], m[8'h70], m[8'h74], m[8'hf0], m[8'hf1], m[8'hf2],
			m[8'hf4], m[8'hf5]};
		chk(eg, {24'h000000, gcfg});
		chk(ef, fcfg);
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		i_gfc_host.io(1'b0, port(), a, q);
		i_gfc_host.io(1'b0, port() + 16'h0001, d, q);
		if (m.exists(a) && !(a >= 8'h30 && m[7] != 8'h00))
			m[a] = d;
		if (a == 8'h02 && d[0])
			mrst(3);
	endtask
	task automatic get(input logic [7:0] a);
		logic [7:0] e;
		e = (m.exists(a) && a != 8'h02 && !(a >= 8'h30 && m[7] != 8'h00)) ? m[a] : 8'h00;
		if (a == 8'h20)
			e = ID;
		if (a == 8'h21)
			e = REV;
		i_gfc_host.io(1'b0, port(), a, q);
		i_gfc_host.io(1'b1, port() + 16'h0001, 8'h00, q);
		chk({1'b1, e}, q);
	endtask
	task automatic sweep(input bit w);
		for (int k = 0; k < 256; k++)
			if (k != 8'haa && !(w && k == 7))
			begin
				if (w)
					put(k[7:0], 8'($random(seed)));
				else
					get(k[7:0]);
			end
		if (!w)
			outs();
	endtask
	task automatic enter();
		i_gfc_host.io(1'b0, port(), GFC_KEY_ENTER, q);
		chk(9'h001, {8'h00, cfg});
	endtask
	task automatic pulse(input int s);
		@(posedge clock);
		#1 rp[s] = 1'b1;
		repeat (6) @(posedge clock);
		#1 rp[s] = 1'b0;
		repeat (4) @(posedge clock);
		#1 mrst(s);
		chk(9'h000, {8'h00, cfg});
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		mrst(1);
		repeat (6) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clock);
		i_gfc_host.io(1'b1, port() + 16'h0001, 8'h00, q);
		chk(9'h000, q);
		enter();
		sweep(1'b0);
		for (p = 0; p < 2; p++)
		begin
			put(8'h07, p[7:0]);
			sweep(1'b1);
			sweep(1'b0);
		end
		put(8'h02, 8'h01);
		sweep(1'b0);
		for (p = 0; p < 3; p++)
		begin
			put(8'h07, 8'h00);
			sweep(1'b1);
			strap = (p == 1);
			pulse(p);
			enter();
			sweep(1'b0);
		end
		i_gfc_host.io(1'b1, port(), 8'h00, q);
		chk(9'h1ff, q);
		i_gfc_host.io(1'b0, port(), GFC_KEY_EXIT, q);
		chk(9'h000, {8'h00, cfg});
		i_gfc_host.io(1'b1, port() + 16'h0001, 8'h00, q);
		chk(9'h000, q);
		end_of_test();
	end
	initial
	begin
		#800000;
		error_cnt++;
		end_of_test();
	end
endmodule
